// *** rtl/msep_top.v ***
/*
 * Mode selection at reset release and on-chip EPROM programming control.
 * Holds the EPROM array, the program control register on AXI4-Lite and
 * the self-check LED report. Assumes the CPU memory port is on aclk and
 * that the mode pins come from outside and need synchronising.
 */
`timescale 1ns/10ps
`include "msep_defs.vh"

module msep_top
#(
    parameter FLASH_CYCLES = 25000000, // LED flash half period in cycles
    parameter CHAR_DEPTH = 4096, // Character EPROM bytes
    parameter USER_DEPTH = 24064 // User EPROM bytes
)
(
    input wire aclk, // System clock, 250 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire [9:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output wire s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output wire s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [9:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output wire s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire irq_high_level, // Elevated level detected on interrupt pin
    input wire mode_select_pin, // Mode-select port pin level
    output wire mode_pin_claimed, // High while the pin is held for sampling
    output reg self_check_mode_ff, // Self-check/bootstrap mode selected
    output reg [15:0] start_addr_ff, // Where the CPU begins after reset
    input wire [15:0] cpu_addr, // CPU address
    input wire cpu_wr, // CPU write strobe, one cycle
    input wire [7:0] cpu_wdata, // CPU write data
    input wire cpu_rd, // CPU read strobe, one cycle
    output reg [7:0] cpu_rdata_ff, // EPROM read data, next cycle
    output reg cpu_rvalid_ff, // EPROM read data valid, one cycle
    output wire prog_power_on, // Programming power connected to array
    output reg [3:0] led_n_ff // Port-A LED bits, 1 means off
);

    localparam MEM_DEPTH = CHAR_DEPTH + USER_DEPTH;

    // Mode pins pass two flops; these flops are data only, not reset
    reg irq_s1_ff;
    reg irq_s2_ff;
    reg pin_s1_ff;
    reg pin_s2_ff;
    reg sampled_ff;
    reg pin_latched_ff;

    // Control and self-test state
    reg latch_ff;
    reg prog_ff;
    reg prog_d_ff;
    reg held_ff;
    reg [15:0] held_addr_ff;
    reg [7:0] held_data_ff;
    reg [4:0] selftest_ff;

    // AXI write side state
    reg aw_got_ff;
    reg w_got_ff;
    reg [9:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;

    // Flash divider
    reg [31:0] div_ff;
    reg flash_tick_ff;

    reg [7:0] mem [0:MEM_DEPTH-1];
    integer i;

    wire commit;
    wire [7:0] pcvalue;
    wire cpu_hit;
    wire [14:0] cpu_index;
    wire [14:0] held_index;
    wire [3:0] led_n_w;
    reg [31:0] rd_mux;
    reg rd_ok;

    // Cells leave the die erased
    initial
    begin
        for (i = 0; i < MEM_DEPTH; i = i + 1)
            mem[i] = `MSEP_ERASED; // RQ10
    end

    // Map a CPU address into the packed array, character window first
    function [14:0] msep_index;
        input [15:0] addr;
        reg [15:0] off;
        begin
            off = 16'h0000;
            if (addr <= `MSEP_CHAR_LAST)
                off = addr - `MSEP_CHAR_BASE;
            else
                off = addr - `MSEP_USER_BASE + {1'b0, `MSEP_CHAR_SIZE};
            msep_index = off[14:0];
        end
    endfunction

    // Only the two documented windows answer as EPROM
    assign cpu_hit = ((cpu_addr >= `MSEP_CHAR_BASE) && (cpu_addr <= `MSEP_CHAR_LAST)) ||
                     ((cpu_addr >= `MSEP_USER_BASE) && (cpu_addr <= `MSEP_USER_LAST)); // RQ9
    assign cpu_index = msep_index(cpu_addr);
    assign held_index = msep_index(held_addr_ff);

    // Synchronisers for the two mode pins
    always @(posedge aclk)
    begin
        irq_s1_ff <= irq_high_level;
        irq_s2_ff <= irq_s1_ff;
        pin_s1_ff <= mode_select_pin;
        pin_s2_ff <= pin_s1_ff;
    end

    // Mode is caught on the first edge after reset release. The pins
    // keep moving through the synchroniser during reset, so the value
    // seen then is the level held across the release edge.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sampled_ff <= 1'b0;
            pin_latched_ff <= 1'b0;
            self_check_mode_ff <= 1'b0;
            start_addr_ff <= `MSEP_USER_VECTOR;
        end
        else if (!sampled_ff)
        begin
            sampled_ff <= 1'b1; // RQ2
            pin_latched_ff <= pin_s2_ff; // RQ2
            if (irq_s2_ff && pin_s2_ff)
            begin
                self_check_mode_ff <= 1'b1; // RQ3
                start_addr_ff <= `MSEP_SELFTEST_BASE; // RQ5
            end
            else
            begin
                self_check_mode_ff <= 1'b0; // RQ1
                start_addr_ff <= `MSEP_USER_VECTOR; // RQ1
            end
        end
    end

    // Pin goes back to its port function once sampled
    assign mode_pin_claimed = ~sampled_ff; // RQ2

    // AXI handshakes: address and data taken in either order
    assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_ff & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign commit = aw_got_ff & w_got_ff & ~s_axi_bvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 10'h000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MSEP_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (commit)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if ((awaddr_ff == `MSEP_ADDR_PCTRL) || (awaddr_ff == `MSEP_ADDR_STATUS) ||
                    (awaddr_ff == `MSEP_ADDR_SELFTEST))
                    s_axi_bresp <= `MSEP_RESP_OKAY;
                else
                    s_axi_bresp <= `MSEP_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Control register. The program bit can only stand with the latch
    // bit, so a write clearing both ends the cycle in one access.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            latch_ff <= 1'b0; // RQ18
            prog_ff <= 1'b0; // RQ18
            selftest_ff <= `MSEP_SELFTEST_RESET;
        end
        else if (commit && wstrb_ff[0])
        begin
            if (awaddr_ff == `MSEP_ADDR_PCTRL)
            begin
                latch_ff <= wdata_ff[`MSEP_BIT_LATCH]; // RQ11
                prog_ff <= wdata_ff[`MSEP_BIT_PROG] & wdata_ff[`MSEP_BIT_LATCH]; // RQ13 RQ15
            end
            if (awaddr_ff == `MSEP_ADDR_SELFTEST)
                selftest_ff <= wdata_ff[`MSEP_BIT_ST_FAIL:0];
        end
    end

    assign prog_power_on = prog_ff; // RQ13
    assign pcvalue = {6'h00, latch_ff, prog_ff}; // RQ18

    // Read decode; unmapped addresses answer SLVERR with zero data
    always @*
    begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `MSEP_ADDR_PCTRL: rd_mux = {24'h000000, pcvalue};
            `MSEP_ADDR_STATUS:
            begin
                rd_mux[`MSEP_BIT_ST_SELFCHK] = self_check_mode_ff;
                rd_mux[`MSEP_BIT_ST_PIN] = pin_latched_ff;
                rd_mux[`MSEP_BIT_ST_HELD] = held_ff;
                rd_mux[`MSEP_BIT_ST_PWR] = prog_ff;
            end
            `MSEP_ADDR_SELFTEST: rd_mux = {27'h0000000, selftest_ff};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MSEP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `MSEP_RESP_OKAY : `MSEP_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Address and data capture for programming; a new write while the
    // latch is set simply replaces the held pair.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            held_ff <= 1'b0;
            held_addr_ff <= 16'h0000;
            held_data_ff <= 8'h00;
        end
        else if (!latch_ff)
            held_ff <= 1'b0;
        else if (cpu_wr && cpu_hit)
        begin
            held_ff <= 1'b1; // RQ11
            held_addr_ff <= cpu_addr; // RQ11
            held_data_ff <= cpu_wdata; // RQ11
        end
    end

    // Programming can only pull bits from one to zero, as in the cell.
    // The byte is burnt when power is connected; holding it longer is
    // left to software and changes nothing further here.
    always @(posedge aclk)
    begin
        if (!aresetn)
            prog_d_ff <= 1'b0;
        else
            prog_d_ff <= prog_ff;
    end

    always @(posedge aclk)
    begin
        if (prog_ff && !prog_d_ff && held_ff)
            mem[held_index] <= mem[held_index] & held_data_ff; // RQ13
    end

    // CPU reads: blocked while latched, erased value outside the windows
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_rdata_ff <= `MSEP_ERASED;
            cpu_rvalid_ff <= 1'b0;
        end
        else
        begin
            cpu_rvalid_ff <= cpu_rd;
            if (cpu_rd)
            begin
                if (latch_ff || !cpu_hit)
                    cpu_rdata_ff <= `MSEP_ERASED; // RQ11
                else
                    cpu_rdata_ff <= mem[cpu_index]; // RQ12
            end
        end
    end

    // Flash divider; runs only in self-check to save toggling in user mode
    always @(posedge aclk)
    begin
        if (!aresetn || !self_check_mode_ff)
        begin
            div_ff <= 32'h00000000;
            flash_tick_ff <= 1'b0;
        end
        else if (div_ff == FLASH_CYCLES - 1)
        begin
            div_ff <= 32'h00000000;
            flash_tick_ff <= 1'b1;
        end
        else
        begin
            div_ff <= div_ff + 32'h00000001;
            flash_tick_ff <= 1'b0;
        end
    end

    msep_led u_led
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(self_check_mode_ff),
        .flash_tick(flash_tick_ff),
        .test_fail(selftest_ff[`MSEP_BIT_ST_FAIL]),
        .fail_code(selftest_ff[`MSEP_ST_CODE_MSB:0]),
        .led_n_ff(led_n_w)
    );

    always @*
    begin
        led_n_ff = led_n_w;
    end

endmodule

// *** include/msep_defs.vh ***
/*
 * Constants shared by the mode-select and EPROM programming block:
 * register indices, bit fields, memory map, self-check codes.
 * Assumes it is included by its bare name from files under rtl/.
 */
// Functional notes
// (RQ1) Normal interrupt level at reset release: user mode
// (RQ2) Sample mode pin early, then release it
// (RQ3) High interrupt level and pin one: self-check
// (RQ4) Other side holds high level two cycles
// (RQ5) Self-check starts at masked test program
// (RQ6) Passing self-check makes indicator LEDs flash
// (RQ7) Failure shows steady four-bit code, one off
// (RQ8) Other side holds reset long for bootstrap
// (RQ9) Character and user EPROM windows are mapped
// (RQ10) Erased EPROM byte reads all ones
// (RQ11) Latch set: writes captured, reads blocked
// (RQ12) Latch clear: normal EPROM reads
// (RQ13) Program bit powers array, needs latch set
// (RQ14) Software follows the five-step programming order
// (RQ15) One write clearing both bits ends programming
// (RQ16) Software holds program bit about 1 ms
// (RQ17) Software sets latch only with supply present
// (RQ18) Upper control bits zero; reset clears both
`ifndef MSEP_DEFS_VH
`define MSEP_DEFS_VH

// Register indices and their byte addresses (index times four)
`define MSEP_IDX_PCTRL 8'h3D
`define MSEP_IDX_STATUS 8'h3E
`define MSEP_IDX_SELFTEST 8'h3F
`define MSEP_ADDR_PCTRL 10'h0F4
`define MSEP_ADDR_STATUS 10'h0F8
`define MSEP_ADDR_SELFTEST 10'h0FC

// Control register fields
`define MSEP_BIT_PROG 0
`define MSEP_BIT_LATCH 1
`define MSEP_PCTRL_RESET 2'h0

// Status register fields
`define MSEP_BIT_ST_SELFCHK 0
`define MSEP_BIT_ST_PIN 1
`define MSEP_BIT_ST_HELD 2
`define MSEP_BIT_ST_PWR 3

// Self-test register fields
`define MSEP_ST_CODE_MSB 3
`define MSEP_BIT_ST_FAIL 4
`define MSEP_SELFTEST_RESET 5'h00

// EPROM memory map
`define MSEP_CHAR_BASE 16'h8000
`define MSEP_CHAR_LAST 16'h8FFF
`define MSEP_USER_BASE 16'hA000
`define MSEP_USER_LAST 16'hFDFF
`define MSEP_CHAR_SIZE 15'h1000
`define MSEP_ERASED 8'hFF

// Start addresses handed to the CPU
`define MSEP_SELFTEST_BASE 16'hFE00
`define MSEP_USER_VECTOR 16'hFFFE

// Self-check report codes, 1 means LED off
`define MSEP_LED_ALL_OFF 4'hF
`define MSEP_FAIL_PORTA 4'hF
`define MSEP_FAIL_IO 4'hE
`define MSEP_FAIL_RAM 4'hD
`define MSEP_FAIL_ROM 4'hC
`define MSEP_FAIL_TIMER 4'hB
`define MSEP_FAIL_PULSE 4'hA
`define MSEP_FAIL_CONV 4'h9
`define MSEP_FAIL_DISPLAY 4'h8
`define MSEP_FAIL_MFTIMER 4'h7

// AXI responses
`define MSEP_RESP_OKAY 2'h0
`define MSEP_RESP_SLVERR 2'h2

`endif

// *** rtl/msep_led.v ***
/*
 * Self-check indicator driver: flashes the four port-A LEDs while the
 * test program reports a pass, shows a steady code on failure.
 * Assumes a one-cycle flash_tick from the top-level divider.
 */
`timescale 1ns/10ps
`include "msep_defs.vh"

module msep_led
(
    input wire aclk, // System clock
    input wire aresetn, // Synchronous reset, active low
    input wire enable, // Self-check mode active
    input wire flash_tick, // One-cycle pulse per flash half period
    input wire test_fail, // Test program reported a failure
    input wire [3:0] fail_code, // Failure code, 1 means LED off
    output reg [3:0] led_n_ff // LED drive, 1 means LED off
);

    reg phase_ff;
    reg nxt_phase;
    reg [3:0] nxt_led_n;

    // Flash phase only toggles while a pass is reported; a reported failure clears it
    always @*
    begin
        nxt_phase = phase_ff;
        nxt_led_n = `MSEP_LED_ALL_OFF;
        if (enable && !test_fail)
        begin
            if (flash_tick)
                nxt_phase = ~phase_ff;
            nxt_led_n = phase_ff ? ~`MSEP_LED_ALL_OFF : `MSEP_LED_ALL_OFF; // RQ6
        end
        else if (enable)
        begin
            nxt_phase = 1'b0;
            nxt_led_n = fail_code; // RQ7
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            phase_ff <= 1'b0;
            led_n_ff <= `MSEP_LED_ALL_OFF;
        end
        else
        begin
            phase_ff <= nxt_phase;
            led_n_ff <= nxt_led_n;
        end
    end

endmodule

// *** bench/msep_checker.sv ***
/*
 * Concurrent checks on the msep_top ports: mode pick at reset release,
 * CPU EPROM read port, AXI answer holding and the reset state.
 * Assumes one clock domain, aclk, with synchronous active-low aresetn.
 */
`timescale 1ns/10ps
`include "msep_defs.vh"

module msep_checker
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic s_axi_bvalid, // Write answer valid
    input wire logic s_axi_bready, // Write answer ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_rvalid, // Read answer valid
    input wire logic s_axi_rready, // Read answer ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic mode_pin_claimed, // Pin held for sampling
    input wire logic self_check_mode_ff, // Self-check selected
    input wire logic [15:0] start_addr_ff, // CPU start address
    input wire logic cpu_rd, // CPU read strobe
    input wire logic cpu_rvalid_ff, // CPU read answer
    input wire logic [7:0] cpu_rdata_ff, // CPU read data
    input wire logic prog_power_on, // Programming power
    input wire logic [3:0] led_n_ff // LED drive, 1 is off
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Mode is sampled on the first high edge, so stability starts two edges later
    sequence s_settled;
        aresetn && $past(aresetn) && $past(aresetn, 2);
    endsequence
    sequence s_blocked_answer;
        cpu_rvalid_ff && cpu_rdata_ff == `MSEP_ERASED;
    endsequence

    a_claim_released: assert property (aresetn && $past(aresetn) |-> !mode_pin_claimed)
        else $error("mode pin still claimed after release");
    a_reset_state: assert property ($rose(aresetn) |-> !prog_power_on && mode_pin_claimed)
        else $error("reset state wrong at release");
    a_start_vector: assert property ($past(aresetn) |-> start_addr_ff ==
        (self_check_mode_ff ? `MSEP_SELFTEST_BASE : `MSEP_USER_VECTOR))
        else $error("start address does not match mode");
    a_mode_hold: assert property (s_settled |-> $stable(self_check_mode_ff))
        else $error("mode changed after sampling");
    a_led_user: assert property ($past(aresetn) && !self_check_mode_ff |-> led_n_ff == 4'hF)
        else $error("LEDs driven in user mode");
    a_read_blocked: assert property (cpu_rd && prog_power_on |=> s_blocked_answer)
        else $error("EPROM read not blocked while programming");
    a_read_answer: assert property (cpu_rd |=> cpu_rvalid_ff)
        else $error("no read answer one cycle after strobe");
    a_rvalid_cause: assert property (cpu_rvalid_ff |-> $past(cpu_rd))
        else $error("read answer without strobe");
    a_axi_rhold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before ready");
    a_axi_bhold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before ready");
endmodule

bind msep_top msep_checker u_chk
(
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .mode_pin_claimed, .self_check_mode_ff, .start_addr_ff,
    .cpu_rd, .cpu_rvalid_ff, .cpu_rdata_ff, .prog_power_on, .led_n_ff
);

// *** bench/tb_mode_select_eprom_program.sv ***
/*
 * Self-checking bench for msep_top: registers over AXI4-Lite, CPU EPROM
 * port, mode pick at reset release and self-check LED report.
 * Assumes msep_defs.vh on the include path and the bound checker.
 */
`timescale 1ns/10ps
`include "msep_defs.vh"

module tb_mode_select_eprom_program;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, irq_high_level = 0, mode_select_pin = 0;
    logic cpu_wr = 0, cpu_rd = 0;
    logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [15:0] cpu_addr = 0;
    logic [7:0] cpu_wdata = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire mode_pin_claimed, self_check_mode_ff, cpu_rvalid_ff, prog_power_on;
    wire [15:0] start_addr_ff;
    wire [7:0] cpu_rdata_ff;
    wire [3:0] led_n_ff;
    int failures = 0;
    int tests_run = 0;
    int k;
    logic [33:0] q[$];
    logic [15:0] a;
    logic [7:0] d;
    logic [15:0] base[2] = '{16'h8000, 16'hA000};
    logic [3:0] codes[9] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h8, 4'h7};

    // Short flash period keeps the LED scenario brief
    msep_top #(.FLASH_CYCLES(4)) dut
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_high_level, .mode_select_pin,
        .mode_pin_claimed, .self_check_mode_ff, .start_addr_ff, .cpu_addr, .cpu_wr,
        .cpu_wdata, .cpu_rd, .cpu_rdata_ff, .cpu_rvalid_ff, .prog_power_on, .led_n_ff
    );

    // 250 MHz clock
    initial
    begin
        forever #2 aclk = ~aclk;
    end

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    task automatic guard(input int n);
        if (n >= 50)
        begin
            failures++;
            conclude();
        end
    endtask

    // Each answer is matched against the oldest noted expectation
    always @(posedge aclk)
    begin
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", q.size() ? q.pop_front() : 34'h3, {s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", q.size() ? q.pop_front() : 34'h3, {s_axi_rresp, s_axi_rdata});
        if (cpu_rvalid_ff)
            chk("cpu_rdata", q.size() ? q.pop_front() : 34'h3, {26'h0, cpu_rdata_ff});
    end

    // Answer ready goes up with the request and stays until the answer is seen;
    // an idle edge at the end keeps two calls from touching one signal at once
    task automatic axi_wr(input logic [9:0] ad, input logic [7:0] dt, input logic [1:0] r);
        int n;
        s_axi_awaddr <= ad;
        s_axi_wdata <= {24'h0, dt};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        q.push_back({r, 32'h0});
        n = 0;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        guard(n);
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [9:0] ad, input logic [33:0] e);
        int n;
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        q.push_back(e);
        n = 0;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n++;
        end
        while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        guard(n);
        @(posedge aclk);
    endtask

    task automatic cpu_read(input logic [15:0] ad, input logic [7:0] e);
        cpu_addr <= ad;
        cpu_rd <= 1'b1;
        q.push_back({26'h0, e});
        @(posedge aclk);
        cpu_rd <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic cpu_write(input logic [15:0] ad, input logic [7:0] dt);
        cpu_addr <= ad;
        cpu_wdata <= dt;
        cpu_wr <= 1'b1;
        @(posedge aclk);
        cpu_wr <= 1'b0;
        @(posedge aclk);
    endtask

    // Pins are held past the sampling edge, then the mode pin goes random
    task automatic do_reset(input logic hi, input logic pin);
        aresetn <= 1'b0;
        irq_high_level <= hi;
        mode_select_pin <= pin;
        // Bootstrap entry gets the long reset, plain resets the short one
        repeat ((hi & pin) ? 4064 : 3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        irq_high_level <= 1'b0;
        mode_select_pin <= 1'($urandom);
        repeat (2) @(posedge aclk);
        chk("mode", {17'h0, hi & pin, (hi & pin) ? `MSEP_SELFTEST_BASE : `MSEP_USER_VECTOR},
            {17'h0, self_check_mode_ff, start_addr_ff});
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(78));
        do_reset(1'b0, 1'b1);
        axi_rd(`MSEP_ADDR_PCTRL, 34'h0);
        axi_wr(`MSEP_ADDR_PCTRL, 8'hFF, `MSEP_RESP_OKAY);
        axi_rd(`MSEP_ADDR_PCTRL, 34'h3);
        axi_wr(`MSEP_ADDR_PCTRL, 8'h01, `MSEP_RESP_OKAY);
        axi_rd(`MSEP_ADDR_PCTRL, 34'h0);
        axi_wr(10'h200, 8'h02, `MSEP_RESP_SLVERR);
        axi_rd(10'h200, {`MSEP_RESP_SLVERR, 32'h0});
        foreach (base[i])
        begin
            a = base[i] + 16'($urandom_range(0, 4095));
            d = 8'($urandom_range(0, 254));
            cpu_read(a, `MSEP_ERASED);
            axi_wr(`MSEP_ADDR_PCTRL, 8'h02, `MSEP_RESP_OKAY);
            cpu_write(a, d);
            axi_rd(`MSEP_ADDR_STATUS, 34'h6);
            cpu_read(a, `MSEP_ERASED);
            axi_wr(`MSEP_ADDR_PCTRL, 8'h03, `MSEP_RESP_OKAY);
            chk("power", 34'h1, {33'h0, prog_power_on});
            // Programming hold is shortened; the array model burns at once
            repeat (8) @(posedge aclk);
            cpu_read(a, `MSEP_ERASED);
            axi_wr(`MSEP_ADDR_PCTRL, 8'h00, `MSEP_RESP_OKAY);
            chk("power", 34'h0, {33'h0, prog_power_on});
            axi_rd(`MSEP_ADDR_STATUS, 34'h2);
            cpu_read(a, d);
        end
        a = 16'hC000 + 16'($urandom_range(0, 4095));
        cpu_write(a, 8'h00);
        cpu_read(a, `MSEP_ERASED);
        cpu_read(16'h9000, `MSEP_ERASED);
        axi_wr(`MSEP_ADDR_PCTRL, 8'h03, `MSEP_RESP_OKAY);
        do_reset(1'b1, 1'b1);
        chk("power", 34'h0, {33'h0, prog_power_on});
        axi_rd(`MSEP_ADDR_PCTRL, 34'h0);
        k = 0;
        repeat (20)
        begin
            @(posedge aclk);
            k += (led_n_ff == 4'h0);
        end
        chk("flash", 34'h1, {33'h0, k >= 8 && k <= 12});
        foreach (codes[i])
        begin
            axi_wr(`MSEP_ADDR_SELFTEST, {4'h1, codes[i]}, `MSEP_RESP_OKAY);
            repeat (7) @(posedge aclk);
            chk("led", {30'h0, codes[i]}, {30'h0, led_n_ff});
        end
        do_reset(1'b1, 1'b0);
        conclude();
    end
endmodule
